// [rtl/wfs_wake_filter_store.v]
`timescale 1ns/1ns
`include "wfs_map.vh"
//Contract
// - four 32-bit mask words per filter are held in filter order first.
// - mask word 0 gives mask bits 31:0, lsb for the earliest byte.
// - mask word 1 gives mask bits 63:32, lsb for the earliest byte.
// - mask word 2 gives mask bits 95:64, lsb for the earliest byte.
// - mask word 3 gives mask bits 127:96, lsb for the earliest byte.
// - byte offset+j, up to byte 255, feeds a filter's crc exactly when mask bit j is one.
// - 40 indexed writes load the store from word 0 after reset; reads too.
// - command bit 0 enables a filter, bits 3:2 pick the address type.
// - the 8-bit offset counts from the first destination byte as 0.
// - each crc starts at all ones per frame, updated on selected bytes.
module wfs_wake_filter_store (
	input  wire        sys_clk_i,
	input  wire        arst_n_i,
	input  wire        soft_rst_i,
	input  wire        load_wr_i,
	input  wire [31:0] load_wdata_i,
	input  wire        load_rd_i,
	input  wire        rx_sof_i,
	input  wire        rx_valid_i,
	input  wire [7:0]  rx_data_i,
	output reg  [31:0] load_rdata_o,
	output reg  [7:0]  byte_qual_o,
	output reg  [7:0]  filter_en_o,
	output reg  [15:0] addr_type_o,
	output reg  [7:0]  crc_match_o,
	output reg  [127:0] crc_o
);
	// index points at the next word for both reads and writes
	reg [31:0]             store_reg [0:`WFS_WORDS-1];
	reg [`WFS_IDX_W-1:0]   idx_reg;
	reg [`WFS_IDX_W-1:0]   idx_next;
	reg [7:0]              pos_reg;
	reg                    pos_sat_reg;
	reg [15:0]             crc_reg [0:`WFS_FILTERS-1];
	wire [7:0]             qual;
	wire [127:0]           crc_step;
	reg [7:0]              pos_next;
	reg                    sat_next;
	integer                n;

	function [`WFS_IDX_W-1:0] idx_inc;
		input [`WFS_IDX_W-1:0] cur;
		begin
			if (cur == `WFS_LAST_IDX)
				idx_inc = `WFS_MASK_BASE;
			else
				idx_inc = cur + 6'h01;
		end
	endfunction

	// byte lane of a packed word, lane 0 in the least significant byte
	function [7:0] lane8;
		input [31:0] word;
		input integer lane;
		begin
			lane8 = word[8*lane +: 8];
		end
	endfunction

	// half of a packed word, half 0 in the low sixteen bits
	function [15:0] lane16;
		input [31:0] word;
		input integer half;
		begin
			lane16 = word[16*half +: 16];
		end
	endfunction

	// one while pos lies in the 128-byte window that starts at ofs
	function in_win;
		input [7:0] pos;
		input [7:0] ofs;
		reg   [8:0] rel;
		begin
			rel = {1'b0, pos} - {1'b0, ofs};
			in_win = !rel[8] && !rel[7];
		end
	endfunction

	always @*
	begin
		idx_next = idx_reg;
		if (load_wr_i || load_rd_i)
			idx_next = idx_inc(idx_reg);
	end

	always @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			idx_reg <= `WFS_MASK_BASE;
			for (n = 0; n < `WFS_WORDS; n = n + 1)
				store_reg[n] <= `WFS_WORD_RST;
		end
		else if (soft_rst_i)
		begin
			idx_reg <= `WFS_MASK_BASE;
			for (n = 0; n < `WFS_WORDS; n = n + 1)
				store_reg[n] <= `WFS_WORD_RST;
		end
		else
		begin
			idx_reg <= idx_next;
			if (load_wr_i)
				store_reg[idx_reg] <= load_wdata_i;
		end
	end

	// a read in the same cycle as a write returns the old word
	always @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			load_rdata_o <= `WFS_WORD_RST;
		else if (soft_rst_i)
			load_rdata_o <= `WFS_WORD_RST;
		else if (load_rd_i)
			load_rdata_o <= store_reg[idx_reg];
	end

	// frame byte position, wrapping to 0 after byte 255 and then held by a sticky flag so long frames stop matching windows
	always @*
	begin
		pos_next = pos_reg;
		sat_next = pos_sat_reg;
		if (soft_rst_i || rx_sof_i)
		begin
			pos_next = 8'h00;
			sat_next = 1'b0;
		end
		else if (rx_valid_i && !pos_sat_reg)
		begin
			pos_next = pos_reg + 8'h01;
			if (pos_reg == 8'hFF)
				sat_next = 1'b1;
		end
	end

	always @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			pos_reg     <= 8'h00;
			pos_sat_reg <= 1'b0;
		end
		else
		begin
			pos_reg     <= pos_next;
			pos_sat_reg <= sat_next;
		end
	end

	genvar f;
	generate
		for (f = 0; f < `WFS_FILTERS; f = f + 1)
		begin : g_filt
			wire [7:0]   cmd;
			wire [7:0]   ofs;
			wire [15:0]  exp_crc;
			wire [127:0] mask;
			wire [8:0]   rel;
			wire         hit;
			assign cmd = lane8(store_reg[`WFS_CMD_BASE + f/4], f % 4);
			assign ofs = lane8(store_reg[`WFS_OFS_BASE + f/4], f % 4);
			assign exp_crc = lane16(store_reg[`WFS_CRC_BASE + f/2], f % 2);
			assign hit = (crc_reg[f] == exp_crc);
			assign mask = {store_reg[4*f+3], store_reg[4*f+2],
				store_reg[4*f+1], store_reg[4*f]};
			assign rel = {1'b0, pos_reg} - {1'b0, ofs};
			// a sof cycle carries no byte, so it never qualifies one
			assign qual[f] = rx_valid_i && !rx_sof_i && !pos_sat_reg &&
				in_win(pos_reg, ofs) && mask[rel[6:0]];
			wfs_crc16 u_crc (
				.crc_i  (crc_reg[f]),
				.data_i (rx_data_i),
				.crc_o  (crc_step[16*f +: 16])
			);
			always @(posedge sys_clk_i or negedge arst_n_i)
			begin
				if (!arst_n_i)
					crc_reg[f] <= `WFS_CRC_INIT;
				else if (soft_rst_i || rx_sof_i)
					crc_reg[f] <= `WFS_CRC_INIT;
				else if (qual[f])
					crc_reg[f] <= crc_step[16*f +: 16];
			end
			always @(posedge sys_clk_i or negedge arst_n_i)
			begin
				if (!arst_n_i)
				begin
					filter_en_o[f]       <= 1'b0;
					addr_type_o[2*f +: 2] <= 2'h0;
					crc_match_o[f]       <= 1'b0;
					crc_o[16*f +: 16]    <= `WFS_CRC_INIT;
				end
				else
				begin
					filter_en_o[f] <= cmd[`WFS_CMD_EN_BIT];
					addr_type_o[2*f +: 2] <=
						cmd[`WFS_CMD_AT_HI:`WFS_CMD_AT_LO];
					crc_match_o[f] <= hit;
					crc_o[16*f +: 16] <= crc_reg[f];
				end
			end
		end
	endgenerate

	// registered qualify lags the byte by one cycle
	always @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			byte_qual_o <= 8'h00;
		else
			byte_qual_o <= qual;
	end
endmodule // wfs_wake_filter_store

// [rtl/wfs_map.vh]
`ifndef WFS_MAP_VH
`define WFS_MAP_VH
`define WFS_WORDS       40
`define WFS_IDX_W       6
`define WFS_FILTERS     8
`define WFS_MASK_BASE   6'h00
`define WFS_CMD_BASE    6'h20
`define WFS_OFS_BASE    6'h22
`define WFS_CRC_BASE    6'h24
`define WFS_LAST_IDX    6'h27
`define WFS_CMD_EN_BIT  0
`define WFS_CMD_AT_LO   2
`define WFS_CMD_AT_HI   3
`define WFS_CRC_INIT    16'hFFFF
`define WFS_WORD_RST    32'h0000_0000
`endif

// [rtl/wfs_crc16.v]
`timescale 1ns/1ns
// one byte step of the filter crc-16, bit 0 of the byte taken first
module wfs_crc16 (
	input  wire [15:0] crc_i,
	input  wire [7:0]  data_i,
	output wire [15:0] crc_o
);
	wire [7:0] f;
	assign f[0] = crc_i[15] ^ data_i[0];
	genvar k;
	generate
		for (k = 1; k < 8; k = k + 1)
		begin : g_f
			assign f[k] = crc_i[15-k] ^ f[k-1] ^ data_i[k];
		end
	endgenerate
	assign crc_o = {crc_i[7] ^ f[7], crc_i[6:2], crc_i[1] ^ f[0],
		crc_i[0] ^ f[1], f[0] ^ f[2], f[1] ^ f[3], f[2] ^ f[4],
		f[3] ^ f[5], f[4] ^ f[6], f[5] ^ f[7], f[6], f[7]};
endmodule // wfs_crc16

// [verification/wfs_chk.sv]
`timescale 1ns/1ns
module wfs_chk (
	input wire         sys_clk_i,
	input wire         arst_n_i,
	input wire         soft_rst_i,
	input wire         load_wr_i,
	input wire         load_rd_i,
	input wire         rx_sof_i,
	input wire         rx_valid_i,
	input wire [31:0]  load_rdata_o,
	input wire [7:0]   byte_qual_o,
	input wire [7:0]   filter_en_o,
	input wire [127:0] crc_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);
	// crc_o lags a byte by two edges, so sof or soft reset must be quiet twice
	wire calm = !rx_sof_i && !soft_rst_i;
	wire still = !load_wr_i && !soft_rst_i;
	soft_clr_a: assert property (soft_rst_i [*2] |=>
		crc_o == {8{16'hFFFF}} && filter_en_o == 0) else $error("soft clr");
	sof_init_a: assert property (rx_sof_i ##1 !rx_valid_i [*2] |=>
		crc_o == {8{16'hFFFF}}) else $error("sof init");
	qual_idle_a: assert property (!rx_valid_i |=> byte_qual_o == 0)
		else $error("idle qual");
	sof_qual_a: assert property (rx_sof_i |=> byte_qual_o == 0)
		else $error("sof qual");
	skip_hold_a: assert property (byte_qual_o == 0 && calm &&
		$past(calm) && $past(calm, 2) |=> $stable(crc_o)) else $error("skip");
	idle_hold_a: assert property ((!rx_valid_i && calm) [*4] |->
		$stable(crc_o)) else $error("idle crc");
	rd_hold_a: assert property (!load_rd_i && !soft_rst_i &&
		!$past(soft_rst_i) |=> $stable(load_rdata_o)) else $error("rd hold");
	cfg_hold_a: assert property (still && $past(still) |=>
		$stable(filter_en_o)) else $error("cfg hold");
endmodule // wfs_chk
bind wfs_wake_filter_store wfs_chk u_chk (.*);

// [verification/testbench.sv]
`timescale 1ns/1ns
module testbench;
	reg          sys_clk_i = 0;
	reg          arst_n_i, soft_rst_i, load_wr_i, load_rd_i;
	reg          rx_sof_i, rx_valid_i;
	reg  [31:0]  load_wdata_i;
	reg  [7:0]   rx_data_i;
	wire [31:0]  load_rdata_o;
	wire [7:0]   byte_qual_o, filter_en_o, crc_match_o;
	wire [15:0]  addr_type_o;
	wire [127:0] crc_o;
	reg  [31:0]  w [0:39];
	integer      error_cnt = 0, samples_checked = 0, cyc = 0, i, f;
	reg  [7:0]   q;
	reg  [15:0]  ec [0:7];
	wfs_wake_filter_store DUT (.*);
	initial forever #20 sys_clk_i = ~sys_clk_i;
	task chk(input [63:0] n, input [31:0] e, input [31:0] s);
	begin
		samples_checked = samples_checked + 1;
		if (s !== e)
		begin
			error_cnt = error_cnt + 1;
			$display("ERROR %0s exp %h got %h", n, e, s);
		end
	end
	endtask
	task wr(input [31:0] d);
	begin
		@(negedge sys_clk_i);
		load_wr_i = 1;
		load_wdata_i = d;
	end
	endtask
	// expected qualify bits from the written words, not from the design
	function [7:0] expq(input integer p);
		integer f, k;
		begin
			expq = 0;
			for (f = 0; f < 8; f = f + 1)
			begin
				k = p - w[34 + f / 4][8 * (f % 4) +: 8];
				if (k >= 0 && k < 128) expq[f] = w[4 * f + k / 32][k % 32];
			end
		end
	endfunction
	// crc-16 byte step written from the rule, data bit 0 first
	function [15:0] crcf(input [15:0] c, input [7:0] d);
		integer b;
		reg [7:0] x;
		begin
			x[0] = c[15] ^ d[0];
			for (b = 1; b < 8; b = b + 1)
				x[b] = c[15 - b] ^ x[b - 1] ^ d[b];
			crcf = {c[7] ^ x[7], c[6:2], c[1] ^ x[0], c[0] ^ x[1],
				x[0] ^ x[2], x[1] ^ x[3], x[2] ^ x[4], x[3] ^ x[5],
				x[4] ^ x[6], x[5] ^ x[7], x[6], x[7]};
		end
	endfunction
	task end_of_test;
	begin
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	end
	endtask
	always @(posedge sys_clk_i)
	begin
		cyc = cyc + 1;
		if (cyc == 2000)
		begin
			error_cnt = error_cnt + 1;
			end_of_test;
		end
	end
	initial
	begin
		{arst_n_i, load_wr_i, load_rd_i, rx_sof_i, rx_valid_i} = 0;
		soft_rst_i = 1;
		load_wdata_i = 0;
		rx_data_i = 0;
		for (i = 0; i < 40; i = i + 1)
			w[i] = 0;
		w[0] = 32'h0000_0005;
		w[1] = 32'h0000_0001;
		w[6] = 32'h0000_0002;
		w[11] = 32'h8000_0000;
		w[32] = 32'h0005_0901;
		w[33] = 32'h0000_0D00;
		w[34] = 32'h0010_0D0E;
		w[39] = 32'hFFFF_1234;
		repeat (20) @(negedge sys_clk_i);
		arst_n_i = 1;
		repeat (2) @(negedge sys_clk_i);
		soft_rst_i = 0;
		for (i = 0; i < 40; i = i + 1)
			wr(w[i]);
		@(negedge sys_clk_i);
		load_wr_i = 0;
		@(negedge sys_clk_i);
		chk("enable", 8'h27, filter_en_o);
		chk("addrtype", 16'h0C18, addr_type_o);
		// index wrapped to word 0, so reads run back to back from the top
		for (i = 0; i <= 40; i = i + 1)
		begin
			@(negedge sys_clk_i);
			if (i > 0) chk("word", w[i - 1], load_rdata_o);
			load_rd_i = (i < 40);
		end
		$display("load test done");
		@(negedge sys_clk_i);
		rx_sof_i = 1;
		@(negedge sys_clk_i);
		rx_sof_i = 0;
		repeat (2) @(negedge sys_clk_i);
		for (f = 0; f < 8; f = f + 1)
			ec[f] = 16'hFFFF;
		for (i = 0; i <= 200; i = i + 1)
		begin
			@(negedge sys_clk_i);
			if (i > 0) chk("qual", expq(i - 1), byte_qual_o);
			rx_valid_i = (i < 200);
			rx_data_i = i;
			q = expq(i);
			for (f = 0; f < 8; f = f + 1)
				if (i < 200 && q[f])
					ec[f] = crcf(ec[f], i[7:0]);
		end
		repeat (2) @(negedge sys_clk_i);
		for (f = 0; f < 8; f = f + 1)
		begin
			chk("crc", ec[f], crc_o[16 * f +: 16]);
			chk("match", w[36 + f / 2][16 * (f % 2) +: 16] == ec[f],
				crc_match_o[f]);
		end
		$display("frame test done");
		end_of_test;
	end
endmodule // testbench
